/* File: hdl/modem_uart_control_lines.sv */
// Function
// [RULE1] Data output idles high when not sending
// [RULE2] Weak pull-ups on data, RTS, DTR inputs
// [RULE3] CTS driven ON at initialisation
// [RULE4] Flow control: CTS ON only when receiver ready
// [RULE5] No flow control: CTS follows idle setting
// [RULE6] Multiplexer: flow via commands, CTS shows power
// [RULE7] RTS OFF pauses transmission when flow enabled
// [RULE8] Terminal accepts characters after dropping RTS
// [RULE9] RTS rising edge wakes device, 20 ms
// [RULE10] RTS power save: port follows RTS level
// [RULE11] DSR OFF in command modes, ON in data
// [RULE12] Deselected DSR/DCD tracking holds line ON
// [RULE13] DTR drop: data to online command, OK
// [RULE14] DCD OFF at start, ON with call
// [RULE15] Packet dial: data mode, DCD before CONNECT
// [RULE16] DCD ON during prompted input entry
// [RULE17] DCD stays ON in online command mode; code keeps it ON there only while a call or input cause is live
// [RULE18] DCD held until last cause ends
// [RULE19] Ring cadence 1 s ON, 4 s OFF
// [RULE20] Message arrival gives 1 s ring pulse
// [RULE21] Repeated ring events restart ON period
// [RULE22] Cadence timed by prescaled clock counters
`timescale 1ns/10ps
`default_nettype none
`include "uart_ctl_cfg.svh"

module modem_uart_control_lines
	import uart_ctl_pkg::*;
#(
	parameter int P_TICK_CYCLES = `TICK_CYCLES,
	parameter int P_RI_ON_MS    = `RI_ON_MS,
	parameter int P_RI_OFF_MS   = `RI_OFF_MS,
	parameter int P_WAKE_MS     = `WAKE_MS,
	parameter int P_BIT_CYCLES  = `BIT_CYCLES
)
(
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	// Avalon-MM slave
	input  wire logic [2:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output var  logic [31:0] o_avs_readdata,
	output var  logic        o_avs_waitrequest,
	// Terminal side inputs, low is ON
	input  wire logic        i_txd,
	input  wire logic        i_rts_n,
	input  wire logic        i_dtr_n,
	// Terminal side outputs, low is ON
	output var  logic        o_rxd,
	output var  logic        o_cts_n,
	output var  logic        o_dsr_n,
	output var  logic        o_dcd_n,
	output var  logic        o_ri_n,
	// Pad pull-up enables: data, RTS, DTR inputs
	output var  logic [2:0]  o_pull_en
);

	localparam int MW = 16;
	localparam int BW = $clog2(P_BIT_CYCLES + 1);

	initial
	begin
		if (P_RI_ON_MS < 1 || P_RI_OFF_MS < 1 || P_RI_ON_MS + P_RI_OFF_MS >= 2**MW)
			$error("ring cadence does not fit the ms counters");
		if (P_WAKE_MS < 1 || P_WAKE_MS >= 2**MW)
			$error("wake delay does not fit the ms counter");
		if (P_BIT_CYCLES < 2)
			$error("bit time too short");
	end

	// ----------------------------------------
	// Millisecond time base
	// ----------------------------------------
	logic ms_tick;

	// [RULE22] prescaled ms tick
	tick_prescaler #(.P_DIV(P_TICK_CYCLES)) u_tick
	(
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.o_tick  (ms_tick)
	);

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	ctrl_t       ctrl_reg;
	ctrl_t       ctrl_next;
	mode_t       mode_reg;
	mode_t       mode_next;
	logic        wait_reg;
	logic        wait_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [1:0]  flags_reg;
	logic [1:0]  flags_next;
	logic [7:0]  ev;
	logic        wr_take;
	logic        tx_load;
	logic [31:0] status;
	logic        rts_on;
	logic        rts_prev_reg;
	logic        dtr_prev_reg;
	logic        dtr_drop;
	logic        port_en_reg;
	logic        awake;
	logic [MW-1:0] wake_reg;
	logic        tx_busy;
	logic        hold_valid_reg;
	logic        ringing_reg;
	logic        call_up_reg;
	logic        input_reg;
	logic        dcd_cause;
	logic        pd_wait_reg;
	logic        pd_wait_next;

	// Write effects land only on the edge where waitrequest is seen low
	always_comb
	begin
		wr_take = i_avs_write & ~wait_reg;
		ev      = (wr_take && i_avs_address == `OFF_EVENT) ? i_avs_writedata[7:0] : 8'h00;
		tx_load = wr_take && i_avs_address == `OFF_TXDATA;
	end

	// Read view of block state
	always_comb
	begin
		status = {20'h00000, input_reg, ringing_reg, call_up_reg,
			port_en_reg & ctrl_reg.rx_accept, ~o_dcd_n, ~o_ri_n,
			tx_busy, awake, port_en_reg, i_txd, ~i_dtr_n, rts_on};
	end

	// Answer one cycle after the request; a full transmit holding word stalls the write
	always_comb
	begin
		wait_next  = ~((i_avs_read | i_avs_write) & wait_reg &
			~(i_avs_write && i_avs_address == `OFF_TXDATA && hold_valid_reg));
		rdata_next = rdata_reg;
		if (i_avs_read & wait_reg)
		begin
			unique case (i_avs_address)
				`OFF_CTRL:   rdata_next = {22'h000000, ctrl_reg};
				`OFF_MODE:   rdata_next = {30'h00000000, mode_reg};
				`OFF_STATUS: rdata_next = status;
				`OFF_FLAGS:  rdata_next = {30'h00000000, flags_reg};
				default:     rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h00000000;
		end
		else
		begin
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// Control, mode and call state
	// ----------------------------------------
	always_comb
	begin
		rts_on   = ~i_rts_n;
		// [RULE13] ON-to-OFF edge of DTR
		dtr_drop = i_dtr_n & ~dtr_prev_reg;
		ctrl_next = ctrl_reg;
		if (wr_take && i_avs_address == `OFF_CTRL)
			ctrl_next = ctrl_t'(i_avs_writedata[9:0]);
		mode_next = mode_reg;
		if (wr_take && i_avs_address == `OFF_MODE && i_avs_writedata[1:0] != 2'h3)
			mode_next = mode_t'(i_avs_writedata[1:0]);
		// [RULE15] packet dial enters data mode
		if (ev[`EV_PD_DIAL])
			mode_next = MODE_DATA;
		// [RULE13] DTR drop wins over a software mode write
		if (dtr_drop && ctrl_reg.dtr_drop_to_online_cmd && mode_reg == MODE_DATA)
			mode_next = MODE_ONLINE_CMD;
		flags_next = flags_reg;
		if (wr_take && i_avs_address == `OFF_FLAGS)
			flags_next = flags_reg & ~i_avs_writedata[1:0];
		// Hardware set wins over a same-cycle clear
		if (dtr_drop && ctrl_reg.dtr_drop_to_online_cmd && mode_reg == MODE_DATA)
			flags_next[`FL_OK_REQ] = 1'b1;
		// [RULE15] CONNECT released once DCD is already ON
		if (mode_reg == MODE_DATA && !o_dcd_n && ev[`EV_PD_DIAL] == 1'b0 && pd_wait_reg)
			flags_next[`FL_CONNECT] = 1'b1;
	end

	// Call and input causes for carrier detect
	logic ringing_next;
	logic call_up_next;
	logic input_next;

	always_comb
	begin
		pd_wait_next = (pd_wait_reg & ~flags_next[`FL_CONNECT]) | ev[`EV_PD_DIAL];
		ringing_next = (ringing_reg | ev[`EV_CALL_RING]) & ~ev[`EV_CALL_ANS] & ~ev[`EV_CALL_UP];
		call_up_next = (call_up_reg | ev[`EV_CALL_UP] | ev[`EV_CALL_ANS]) & ~ev[`EV_CALL_DOWN];
		// [RULE16] prompted input keeps its own cause
		input_next   = (input_reg | ev[`EV_IN_START]) & ~ev[`EV_IN_END];
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctrl_reg     <= ctrl_t'(`CTRL_RESET);
			mode_reg     <= MODE_CMD;
			flags_reg    <= 2'h0;
			dtr_prev_reg <= 1'b1;
			pd_wait_reg  <= 1'b0;
			ringing_reg  <= 1'b0;
			call_up_reg  <= 1'b0;
			input_reg    <= 1'b0;
		end
		else
		begin
			ctrl_reg     <= ctrl_next;
			mode_reg     <= mode_next;
			flags_reg    <= flags_next;
			dtr_prev_reg <= i_dtr_n;
			pd_wait_reg  <= pd_wait_next;
			ringing_reg  <= ringing_next;
			call_up_reg  <= call_up_next;
			input_reg    <= input_next;
		end
	end

	// ----------------------------------------
	// RTS-controlled power saving
	// ----------------------------------------
	logic          psv_rts;
	logic          port_en_next;
	logic [MW-1:0] wake_next;

	always_comb
	begin
		psv_rts = ctrl_reg.power_save_config == 2'h2 && !ctrl_reg.hw_flow_on;
		// [RULE10] in RTS power save, port enabled only while RTS is ON; always enabled otherwise
		port_en_next = psv_rts ? rts_on : 1'b1;
		wake_next = wake_reg;
		// [RULE9] rising RTS starts the wake-up delay
		if (!psv_rts || !rts_on)
			wake_next = '0;
		else if (!rts_prev_reg)
			wake_next = MW'(P_WAKE_MS);
		else if (ms_tick && wake_reg != '0)
			wake_next = wake_reg - 1'b1;
		awake = port_en_reg && wake_reg == '0;
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rts_prev_reg <= 1'b0;
			port_en_reg  <= 1'b1;
			wake_reg     <= '0;
		end
		else
		begin
			rts_prev_reg <= rts_on;
			port_en_reg  <= port_en_next;
			wake_reg     <= wake_next;
		end
	end

	// ----------------------------------------
	// Transmitter, 8N1, lsb first
	// ----------------------------------------
	tx_state_t     tx_state_reg;
	tx_state_t     tx_state_next;
	logic [7:0]    hold_reg;
	logic [7:0]    hold_next;
	logic          hold_valid_next;
	logic [9:0]    shift_reg;
	logic [9:0]    shift_next;
	logic [3:0]    nbit_reg;
	logic [3:0]    nbit_next;
	logic [BW-1:0] bcnt_reg;
	logic [BW-1:0] bcnt_next;
	logic          line_next;

	always_comb
	begin
		tx_state_next   = tx_state_reg;
		hold_next       = hold_reg;
		hold_valid_next = hold_valid_reg;
		shift_next      = shift_reg;
		nbit_next       = nbit_reg;
		bcnt_next       = bcnt_reg;
		if (tx_load)
		begin
			hold_next       = i_avs_writedata[7:0];
			hold_valid_next = 1'b1;
		end
		unique case (tx_state_reg)
			TX_IDLE:
			begin
				// [RULE7] no new character while RTS is OFF
				if (hold_valid_reg && !(ctrl_reg.hw_flow_on && !rts_on))
				begin
					shift_next      = {1'b1, hold_reg, 1'b0};
					nbit_next       = 4'h0;
					bcnt_next       = BW'(P_BIT_CYCLES - 1);
					hold_valid_next = 1'b0;
					tx_state_next   = TX_SEND;
				end
			end
			TX_SEND:
			begin
				// A started character always completes; the terminal absorbs it
				if (bcnt_reg != '0)
					bcnt_next = bcnt_reg - 1'b1;
				else if (nbit_reg == 4'h9)
					tx_state_next = TX_IDLE;
				else
				begin
					shift_next = {1'b1, shift_reg[9:1]};
					nbit_next  = nbit_reg + 4'h1;
					bcnt_next  = BW'(P_BIT_CYCLES - 1);
				end
			end
		endcase
		// [RULE1] line high whenever idle
		line_next = (tx_state_next == TX_SEND) ? shift_next[0] : 1'b1;
		tx_busy   = hold_valid_reg | (tx_state_reg == TX_SEND);
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tx_state_reg   <= TX_IDLE;
			hold_reg       <= 8'h00;
			hold_valid_reg <= 1'b0;
			shift_reg      <= 10'h3FF;
			nbit_reg       <= 4'h0;
			bcnt_reg       <= '0;
			o_rxd          <= 1'b1;
		end
		else
		begin
			tx_state_reg   <= tx_state_next;
			hold_reg       <= hold_next;
			hold_valid_reg <= hold_valid_next;
			shift_reg      <= shift_next;
			nbit_reg       <= nbit_next;
			bcnt_reg       <= bcnt_next;
			o_rxd          <= line_next;
		end
	end

	// ----------------------------------------
	// Ring indicate timing
	// ----------------------------------------
	logic [MW-1:0] phase_reg;
	logic [MW-1:0] phase_next;
	logic [MW-1:0] msg_reg;
	logic [MW-1:0] msg_next;
	logic          ri_on;

	always_comb
	begin
		phase_next = phase_reg;
		// [RULE19] 5 s period, restarts on a new ring
		if (!ringing_next || ev[`EV_CALL_RING])
			phase_next = '0;
		else if (ms_tick)
			phase_next = (phase_reg == MW'(P_RI_ON_MS + P_RI_OFF_MS - 1)) ? '0 : phase_reg + 1'b1;
		msg_next = msg_reg;
		// [RULE20] [RULE21] each message reloads the ON time
		if (ev[`EV_MSG] && ctrl_reg.message_notify_config)
			msg_next = MW'(P_RI_ON_MS);
		else if (ms_tick && msg_reg != '0)
			msg_next = msg_reg - 1'b1;
		// [RULE19] answer drops the pulse at once
		ri_on = (ringing_next && phase_next < MW'(P_RI_ON_MS)) || msg_next != '0;
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			phase_reg <= '0;
			msg_reg   <= '0;
		end
		else
		begin
			phase_reg <= phase_next;
			msg_reg   <= msg_next;
		end
	end

	// ----------------------------------------
	// Modem status pins
	// ----------------------------------------
	lines_t lines_next;

	always_comb
	begin
		// [RULE18] [RULE17] any live cause holds carrier ON; online command mode alone is not a cause
		dcd_cause = call_up_next | input_next | (mode_next == MODE_DATA);
		// [RULE6] multiplexer: pin reports power state only
		if (ctrl_reg.mux_active)
			lines_next.cts_n = ~port_en_next;
		// [RULE4] ready receiver opens the flow
		else if (ctrl_reg.hw_flow_on)
			lines_next.cts_n = ~(port_en_next & ctrl_reg.rx_accept);
		// [RULE5] fixed level when flow control is off
		else
			lines_next.cts_n = ctrl_reg.cts_idle_setting;
		// [RULE11] [RULE12] DSR follows data mode or is forced ON
		lines_next.dsr_n = ctrl_reg.dsr_tracks_mode ? (mode_next != MODE_DATA) : 1'b0;
		// [RULE14] [RULE12] DCD follows causes or is forced ON
		lines_next.dcd_n = ctrl_reg.dcd_tracks_carrier ? ~dcd_cause : 1'b0;
		lines_next.ri_n  = ~ri_on;
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			// [RULE3] [RULE11] [RULE14] initial pin levels
			o_cts_n   <= 1'b0;
			o_dsr_n   <= 1'b1;
			o_dcd_n   <= 1'b1;
			o_ri_n    <= 1'b1;
			// [RULE2] pull-ups on from reset
			o_pull_en <= `PULL_RESET;
		end
		else
		begin
			o_cts_n   <= lines_next.cts_n;
			o_dsr_n   <= lines_next.dsr_n;
			o_dcd_n   <= lines_next.dcd_n;
			o_ri_n    <= lines_next.ri_n;
			o_pull_en <= `PULL_RESET;
		end
	end

	// Bus outputs straight from their flops
	always_comb
	begin
		o_avs_readdata    = rdata_reg;
		o_avs_waitrequest = wait_reg;
	end

endmodule

`default_nettype wire

/* File: hdl/tick_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none

module tick_prescaler
#(
	parameter int P_DIV = 125000
)
(
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	// One-cycle tick every P_DIV cycles
	output var  logic o_tick
);

	localparam int W = $clog2(P_DIV + 1);

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic         tick_next;

	initial
	begin
		if (P_DIV < 2)
			$error("tick_prescaler: P_DIV must be at least 2");
	end

	// Count down and wrap, tick on the wrap
	always_comb
	begin
		tick_next = (cnt_reg == '0);
		cnt_next  = tick_next ? W'(P_DIV - 1) : cnt_reg - 1'b1;
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_reg <= '0;
			o_tick  <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			o_tick  <= tick_next;
		end
	end

endmodule

`default_nettype wire

/* File: hdl/uart_ctl_cfg.svh */
`ifndef UART_CTL_CFG_SVH
`define UART_CTL_CFG_SVH

// ----------------------------------------
// Register word offsets (Avalon word address)
// ----------------------------------------
`define OFF_CTRL    3'h0
`define OFF_MODE    3'h1
`define OFF_EVENT   3'h2
`define OFF_STATUS  3'h3
`define OFF_TXDATA  3'h4
`define OFF_FLAGS   3'h5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RESET  10'h20F
`define PULL_RESET  3'h7

// ----------------------------------------
// Event register bit positions (write pulses)
// ----------------------------------------
`define EV_CALL_RING  0
`define EV_CALL_ANS   1
`define EV_CALL_UP    2
`define EV_CALL_DOWN  3
`define EV_MSG        4
`define EV_IN_START   5
`define EV_IN_END     6
`define EV_PD_DIAL    7

// ----------------------------------------
// Flags register bit positions (write one to clear)
// ----------------------------------------
`define FL_OK_REQ     0
`define FL_CONNECT    1

// ----------------------------------------
// Timing: clock rate, base tick and pulse lengths
// ----------------------------------------
`define CLK_MHZ       125
`define TICK_US       1000
`define TICK_CYCLES   (`TICK_US * `CLK_MHZ)
`define RI_ON_MS      1000
`define RI_OFF_MS     4000
`define WAKE_MS       20
`define BIT_CYCLES    1085

`endif

/* File: hdl/uart_ctl_pkg.sv */
package uart_ctl_pkg;

	// Software controls, msb first as stored in the control word
	typedef struct packed {
		logic       rx_accept;
		logic       mux_active;
		logic       message_notify_config;
		logic [1:0] power_save_config;
		logic       cts_idle_setting;
		logic       dtr_drop_to_online_cmd;
		logic       dcd_tracks_carrier;
		logic       dsr_tracks_mode;
		logic       hw_flow_on;
	} ctrl_t;

	// Modem line modes
	typedef enum logic [1:0] {
		MODE_CMD,
		MODE_DATA,
		MODE_ONLINE_CMD
	} mode_t;

	// Transmitter states
	typedef enum logic {
		TX_IDLE,
		TX_SEND
	} tx_state_t;

	// Modem status outputs, active low as on the pins
	typedef struct packed {
		logic cts_n;
		logic dsr_n;
		logic dcd_n;
		logic ri_n;
	} lines_t;

endpackage

/* File: tb/ctl_checker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "uart_ctl_cfg.svh"

module ctl_checker
#(
	parameter int P_BIT_CYCLES = 4
)
(
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	// Register bus
	input  wire logic [2:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [31:0] o_avs_readdata,
	input  wire logic        o_avs_waitrequest,
	// Terminal side outputs
	input  wire logic        o_rxd,
	input  wire logic        o_cts_n,
	input  wire logic        o_dsr_n,
	input  wire logic        o_dcd_n,
	input  wire logic        o_ri_n,
	input  wire logic [2:0]  o_pull_en
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	logic [15:0] run_reg;
	logic [15:0] run_next;
	logic        rxd_reg;
	logic        wr_ok;

	// Accepted write at its effect edge
	assign wr_ok = i_avs_write && !o_avs_waitrequest;

	// Cycles since the data output last moved, saturating so idle gaps never wrap
	always_comb
	begin
		run_next = (o_rxd != rxd_reg) ? 16'h0001 : ((run_reg == 16'hFFFF) ? run_reg : run_reg + 16'h0001);
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			run_reg <= 16'h0000;
			rxd_reg <= 1'b1;
		end
		else
		begin
			run_reg <= run_next;
			rxd_reg <= o_rxd;
		end
	end

	// ----------------------------------------
	// Sequences and properties
	// ----------------------------------------
	sequence s_mode_data;
		wr_ok && i_avs_address == `OFF_MODE && i_avs_writedata[1:0] == 2'h1;
	endsequence
	sequence s_dcd_cause;
		wr_ok && i_avs_address == `OFF_EVENT && (i_avs_writedata[7] || i_avs_writedata[5]) && !i_avs_writedata[6];
	endsequence
	sequence s_ring;
		wr_ok && i_avs_address == `OFF_EVENT && i_avs_writedata[2:0] == 3'h1;
	endsequence

	property p_pull;
		o_pull_en == 3'h7;
	endproperty
	property p_bit_len;
		(o_rxd != rxd_reg) |-> run_reg >= P_BIT_CYCLES;
	endproperty
	property p_init;
		$rose(i_rst_n) |-> o_rxd && !o_cts_n && o_dsr_n && o_dcd_n && o_ri_n;
	endproperty
	property p_dsr_data;
		s_mode_data |=> !o_dsr_n;
	endproperty
	property p_dcd_cause;
		s_dcd_cause |=> (!o_dcd_n)[*2];
	endproperty
	property p_ring;
		s_ring |=> !o_ri_n;
	endproperty
	property p_wait_one;
		$fell(o_avs_waitrequest) |=> o_avs_waitrequest;
	endproperty
	property p_wait_ans;
		(i_avs_read || (i_avs_write && i_avs_address != `OFF_TXDATA)) && o_avs_waitrequest |=> !o_avs_waitrequest;
	endproperty
	property p_rdata;
		$changed(o_avs_readdata) |-> $fell(o_avs_waitrequest) && $past(i_avs_read);
	endproperty

	a_pull: assert property (p_pull)
		else $error("pull-up enables not all on");
	a_bit_len: assert property (p_bit_len)
		else $error("data output bit shorter than one bit time");
	a_init: assert property (p_init)
		else $error("pin levels wrong at reset release");
	a_dsr_data: assert property (p_dsr_data)
		else $error("DSR not ON after entering data mode");
	a_dcd_cause: assert property (p_dcd_cause)
		else $error("DCD not ON after dial or prompt");
	a_ring: assert property (p_ring)
		else $error("RI not ON after incoming call");
	a_wait_one: assert property (p_wait_one)
		else $error("waitrequest low for more than one cycle");
	a_wait_ans: assert property (p_wait_ans)
		else $error("request not answered next cycle");
	a_rdata: assert property (p_rdata)
		else $error("read data moved outside a read answer");
endmodule
`default_nettype wire

/* File: tb/dte_model.sv */
`timescale 1ns/10ps
`default_nettype none

module dte_model
#(
	parameter int P_BIT_CYCLES = 4
)
(
	// Clock and bench controls
	input  wire logic       i_clock,
	input  wire logic       i_rts_on,
	input  wire logic       i_dtr_on,
	// Device data output
	input  wire logic       i_rxd,
	// Lines towards the device, low is ON
	output var  logic       o_txd,
	output var  logic       o_rts_n,
	output var  logic       o_dtr_n,
	// Received characters
	output var  logic [7:0] o_byte,
	output var  logic [7:0] o_count
);
	// OFF lines and the idle data line are driven high, the device's pull-up level
	assign o_txd   = 1'b1;
	assign o_rts_n = !i_rts_on;
	assign o_dtr_n = !i_dtr_on;

	initial
	begin
		o_byte  = 8'h00;
		o_count = 8'h00;
	end

	// Accepts after RTS drop
	// Sample mid-bit; a bad stop bit drops the character
	always
	begin
		@(negedge i_rxd);
		repeat (P_BIT_CYCLES / 2) @(posedge i_clock);
		for (int i = 0; i < 8; i++)
		begin
			repeat (P_BIT_CYCLES) @(posedge i_clock);
			o_byte[i] = i_rxd;
		end
		repeat (P_BIT_CYCLES) @(posedge i_clock);
		if (i_rxd === 1'b1)
			o_count = o_count + 8'h01;
	end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "uart_ctl_cfg.svh"

`define CHECK(nm, ex, got) \
	begin tests_run++; if ((got) !== (ex)) begin failures++; \
	$display("unexpected %s expected %h seen %h", nm, ex, got); end end

module tb;
	localparam int TICK = 10;
	localparam int RON  = 3;

	logic        i_clock;
	logic        i_rst_n = 1'b0;
	logic [2:0]  avs_address = 3'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic        rts_on = 1'b0;
	logic        dtr_on = 1'b0;
	wire  logic  txd, rts_n, dtr_n, rxd, cts_n, dsr_n, dcd_n, ri_n, wait_r;
	wire  logic [2:0]  pull_en;
	wire  logic [31:0] rdata;
	wire  logic [7:0]  rx_byte, rx_count;
	logic [31:0] d;
	int          n;
	int          failures = 0;
	int          tests_run = 0;
	logic [31:0] cts_cfg [4] = '{32'h00F, 32'h20F, 32'h21E, 32'h20E};
	logic        cts_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	modem_uart_control_lines #(.P_TICK_CYCLES(TICK), .P_RI_ON_MS(RON), .P_RI_OFF_MS(5), .P_WAKE_MS(2),
		.P_BIT_CYCLES(4)) uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs_address(avs_address),
		.i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_r), .i_txd(txd), .i_rts_n(rts_n), .i_dtr_n(dtr_n),
		.o_rxd(rxd), .o_cts_n(cts_n), .o_dsr_n(dsr_n), .o_dcd_n(dcd_n), .o_ri_n(ri_n), .o_pull_en(pull_en));
	dte_model #(.P_BIT_CYCLES(4)) dte (.i_clock(i_clock), .i_rts_on(rts_on), .i_dtr_on(dtr_on), .i_rxd(rxd),
		.o_txd(txd), .o_rts_n(rts_n), .o_dtr_n(dtr_n), .o_byte(rx_byte), .o_count(rx_count));

	// 125 MHz clock
	initial
	begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end

	// ----------------------------------------
	// Bus and wait tasks
	// ----------------------------------------
	// Request held until waitrequest is seen low; one idle edge keeps drivers single per step
	task automatic bus_write(input logic [2:0] a, input logic [31:0] v);
		avs_address <= a;
		avs_writedata <= v;
		avs_write <= 1'b1;
		do @(posedge i_clock); while (wait_r !== 1'b0);
		avs_write <= 1'b0;
		@(posedge i_clock);
	endtask

	task automatic bus_read(input logic [2:0] a, output logic [31:0] v);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge i_clock); while (wait_r !== 1'b0);
		v = rdata;
		avs_read <= 1'b0;
		@(posedge i_clock);
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge i_clock);
	endtask

	// Length of the current RI level, capped so a stuck line cannot hang
	task automatic run_len(input logic lvl, output int c);
		c = 0;
		while (ri_n === lvl && c < 1000)
		begin
			@(posedge i_clock);
			c++;
		end
	endtask

	task automatic wait_rx(input int c);
		for (int k = 0; k < 400 && rx_count < c; k++)
			@(posedge i_clock);
	endtask

	task automatic stop_test();
		if (failures == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog sized well above the full sequence
	initial
	begin
		tick(20000);
		failures++;
		stop_test();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		tick(3);
		i_rst_n <= 1'b1;
		tick(1);
		`CHECK("rxd", 1'b1, rxd)
		`CHECK("cts_n", 1'b0, cts_n)
		`CHECK("dsr_n", 1'b1, dsr_n)
		`CHECK("dcd_n", 1'b1, dcd_n)
		`CHECK("pull_en", 3'h7, pull_en)
		bus_read(`OFF_CTRL, d);
		`CHECK("ctrl", 32'h0000020F, d)
		bus_write(3'h6, 32'hFFFFFFFF);
		bus_read(3'h6, d);
		`CHECK("unmapped", 32'h0, d)
		// Flow control on and off, receiver ready and not
		for (int i = 0; i < 4; i++)
		begin
			bus_write(`OFF_CTRL, cts_cfg[i]);
			tick(1);
			`CHECK("cts_n", cts_exp[i], cts_n)
		end
		// RTS controlled power save under the multiplexer
		bus_write(`OFF_CTRL, 32'h34E);
		tick(1);
		bus_read(`OFF_STATUS, d);
		`CHECK("port_off", 1'b0, d[3])
		`CHECK("cts_power", 1'b1, cts_n)
		rts_on <= 1'b1;
		tick(3);
		bus_read(`OFF_STATUS, d);
		`CHECK("port_on", 2'b01, d[4:3])
		`CHECK("cts_power", 1'b0, cts_n)
		tick(25);
		bus_read(`OFF_STATUS, d);
		`CHECK("awake", 1'b1, d[4])
		bus_write(`OFF_CTRL, 32'h20F);
		// Data mode, then DTR drop
		dtr_on <= 1'b1;
		bus_write(`OFF_MODE, 32'h1);
		tick(1);
		`CHECK("dsr_n", 1'b0, dsr_n)
		dtr_on <= 1'b0;
		tick(3);
		`CHECK("dsr_n", 1'b1, dsr_n)
		bus_read(`OFF_MODE, d);
		`CHECK("mode", 32'h2, d)
		bus_read(`OFF_FLAGS, d);
		`CHECK("flags", 32'h1, d)
		bus_write(`OFF_FLAGS, 32'h1);
		bus_write(`OFF_MODE, 32'h3);
		bus_read(`OFF_MODE, d);
		`CHECK("mode", 32'h2, d)
		bus_read(`OFF_FLAGS, d);
		`CHECK("flags", 32'h0, d)
		// Carrier causes overlapping
		bus_write(`OFF_EVENT, 32'h04);
		tick(1);
		`CHECK("dcd_n", 1'b0, dcd_n)
		bus_write(`OFF_MODE, 32'h0);
		bus_write(`OFF_EVENT, 32'h20);
		bus_write(`OFF_EVENT, 32'h08);
		tick(1);
		`CHECK("dsr_n", 1'b1, dsr_n)
		`CHECK("dcd_n", 1'b0, dcd_n)
		bus_write(`OFF_EVENT, 32'h40);
		tick(1);
		`CHECK("dcd_n", 1'b1, dcd_n)
		// Packet data dial
		bus_write(`OFF_EVENT, 32'h80);
		tick(2);
		`CHECK("dcd_n", 1'b0, dcd_n)
		bus_read(`OFF_MODE, d);
		`CHECK("mode", 32'h1, d)
		bus_read(`OFF_FLAGS, d);
		`CHECK("flags", 32'h2, d)
		bus_write(`OFF_FLAGS, 32'h2);
		bus_write(`OFF_MODE, 32'h0);
		// Tracking deselected holds both lines ON
		bus_write(`OFF_CTRL, 32'h209);
		tick(1);
		`CHECK("dsr_dcd", 2'b00, {dsr_n, dcd_n})
		bus_write(`OFF_CTRL, 32'h20F);
		// Ring cadence, then early answer
		bus_write(`OFF_EVENT, 32'h01);
		run_len(1'b0, n);
		`CHECK("ri_on", 1'b1, n >= (RON - 1) * TICK && n <= RON * TICK + 1)
		run_len(1'b1, n);
		`CHECK("ri_off", 1'b1, n >= 49 && n <= 51)
		bus_write(`OFF_EVENT, 32'h02);
		tick(1);
		`CHECK("ri_n", 1'b1, ri_n)
		tick(60);
		`CHECK("ri_n", 1'b1, ri_n)
		// Message pulses, second one restarts the ON time
		bus_write(`OFF_CTRL, 32'h28F);
		bus_write(`OFF_EVENT, 32'h10);
		tick(1);
		`CHECK("ri_n", 1'b0, ri_n)
		tick(15);
		bus_write(`OFF_EVENT, 32'h10);
		run_len(1'b0, n);
		`CHECK("ri_restart", 1'b1, n >= (RON - 1) * TICK - 3 && n <= RON * TICK + 1)
		// Back to back characters, then RTS pause
		bus_write(`OFF_TXDATA, 32'hA5);
		bus_write(`OFF_TXDATA, 32'h3C);
		wait_rx(1);
		`CHECK("rx_byte", 8'hA5, rx_byte)
		wait_rx(2);
		`CHECK("rx_byte", 8'h3C, rx_byte)
		rts_on <= 1'b0;
		bus_write(`OFF_TXDATA, 32'h5A);
		tick(60);
		`CHECK("paused", 9'h102, {rxd, rx_count})
		rts_on <= 1'b1;
		wait_rx(3);
		`CHECK("rx_byte", 8'h5A, rx_byte)
		stop_test();
	end
endmodule

bind modem_uart_control_lines ctl_checker #(.P_BIT_CYCLES(P_BIT_CYCLES)) chk (.i_clock(i_clock),
	.i_rst_n(i_rst_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.o_rxd(o_rxd), .o_cts_n(o_cts_n), .o_dsr_n(o_dsr_n), .o_dcd_n(o_dcd_n), .o_ri_n(o_ri_n),
	.o_pull_en(o_pull_en));
`default_nettype wire
